// ===== flash_array_model.sv
// Behavioural model of the byte-wide flash memory with its command register
`default_nettype none
module flash_array_model (
  input wire logic [16:0] mem_addr,
  input wire logic [7:0] mem_dq_o,
  input wire logic mem_we_n,
  input wire logic mem_oe_n,
  input wire logic mem_ce_n,
  input wire logic vpp_high,
  output logic [7:0] mem_dq_i
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] mem [int];
  logic [7:0] log_q[$];
  int fails = 0;
  int viol = 0;
  int st = 0;
  logic [16:0] lat_a, pa, ea;
  logic [7:0] pd = 8'h00;
  logic [7:0] drv = 8'h00;
  logic bad = 1'b0;
  realtime t0 = 0.0;
  realtime tv = 0.0;
  // Unwritten bytes read as erased
  function automatic logic [7:0] rd(int a);
    return mem.exists(a) ? mem[a] : 8'hFF;
  endfunction
  always @(negedge mem_we_n) if (!mem_ce_n) lat_a = mem_addr;
  always @(posedge mem_we_n) begin
    if (!mem_ce_n) begin
      log_q.push_back(mem_dq_o);
      if (!vpp_high) viol++;
      if (st == 1) begin
        pa = lat_a;
        pd = mem_dq_o;
        t0 = $realtime;
        st = 2;
      end else if (st == 4 && mem_dq_o == 8'h20) begin
        t0 = $realtime;
        st = 5;
      end else begin
        case (mem_dq_o)
          8'h40: st = 1;
          8'h20: st = 4;
          8'hC0: begin
            if (st != 2 || $realtime - t0 < 10000.0) viol++;
            bad = fails > 0;
            if (bad) fails--;
            else mem[pa] = rd(pa) & pd;
            st = 3;
            tv = $realtime;
          end
          8'hA0: begin
            if (st == 5) mem.delete();
            ea = lat_a;
            st = 6;
            tv = $realtime;
          end
          8'h00: st = 0;
          default: viol++;
        endcase
      end
    end
  end
  always @(negedge mem_oe_n) if ((st == 3 || st == 6) && $realtime - tv < 6000.0) viol++;
  // Released data lines toggle so a stale value never passes for an answer
  always @(mem_oe_n, mem_ce_n) begin
    if (!mem_oe_n && !mem_ce_n) drv = st == 3 ? (bad ? ~pd : rd(pa)) : rd(st == 6 ? ea : mem_addr);
    else drv = ~drv;
  end
  assign mem_dq_i = drv;
endmodule
`default_nettype wire

// ===== flash_program_erase_algorithm.sv
// Host sequencer for closed-loop byte programming and chip erase of a parallel flash
`include "flash_seq_cfg.svh"
`default_nettype none
module flash_program_erase_algorithm #(
  parameter int ERASE_PULSE_CYC = `ERASE_PULSE_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic start_program,
  input wire logic start_erase,
  input wire logic [16:0] prog_base,
  input wire logic [16:0] prog_last,
  input wire logic wr_valid,
  input wire logic [7:0] wr_data,
  output logic wr_ready,
  output logic busy,
  output logic done,
  output logic program_error,
  output logic erase_error,
  output logic [9:0] pulse_counter,
  output logic program_supply_high_level,
  output logic [16:0] mem_addr,
  input wire logic [7:0] mem_dq_i,
  output logic [7:0] mem_dq_o,
  output logic mem_dq_oe,
  output logic mem_we_n,
  output logic mem_oe_n,
  output logic mem_ce_n
);
  flash_seq_pkg::state_e state_q;
  flash_seq_pkg::phase_e phase_q;
  flash_seq_pkg::result_e result_q;
  logic [17:0] t_q;
  logic [16:0] addr_q;
  logic [16:0] end_q;
  logic [7:0] data_q;
  logic [7:0] rd_q;
  logic [9:0] cnt_q;
  logic [7:0] dq_meta_q;
  logic [7:0] dq_sync_q;
  logic buf_valid;
  logic [7:0] buf_data;
  logic buf_pop;
  logic wr_state;
  logic rd_state;
  logic t_zero;

  word_buffer2 u_buf (
    .clk(clk),
    .rst_n(rst_n),
    .in_valid(wr_valid),
    .in_data(wr_data),
    .in_ready(wr_ready),
    .out_valid(buf_valid),
    .out_data(buf_data),
    .out_ready(buf_pop)
  );

  assign buf_pop = (state_q == flash_seq_pkg::ST_FETCH) && (phase_q == flash_seq_pkg::PH_PROG) && buf_valid;
  assign t_zero = (t_q == 18'h00000);
  assign wr_state = (state_q == flash_seq_pkg::ST_PSETUP) || (state_q == flash_seq_pkg::ST_PWRITE) ||
                    (state_q == flash_seq_pkg::ST_PVERIFY) || (state_q == flash_seq_pkg::ST_ESETUP) ||
                    (state_q == flash_seq_pkg::ST_EWRITE) || (state_q == flash_seq_pkg::ST_EVERIFY) ||
                    (state_q == flash_seq_pkg::ST_RDCMD);
  assign rd_state = (state_q == flash_seq_pkg::ST_SCAN) || (state_q == flash_seq_pkg::ST_PREAD) ||
                    (state_q == flash_seq_pkg::ST_EREAD);
  assign busy = (state_q != flash_seq_pkg::ST_IDLE);
  assign pulse_counter = cnt_q;
  assign mem_addr = addr_q;
  assign mem_dq_o = data_q;

  // Data pins cross from the asynchronous memory bus
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      dq_meta_q <= 8'h00;
      dq_sync_q <= 8'h00;
    end else begin
      dq_meta_q <= mem_dq_i;
      dq_sync_q <= dq_meta_q;
    end
  end

  // Bus strobes: write low for two cycles, read enable held until capture
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mem_we_n <= 1'b1;
      mem_oe_n <= 1'b1;
      mem_dq_oe <= 1'b0;
      mem_ce_n <= 1'b1;
    end else begin
      mem_we_n <= !(wr_state && (t_q > 18'h00001));
      mem_oe_n <= !(rd_state && !t_zero);
      mem_dq_oe <= wr_state;
      mem_ce_n <= !busy;
    end
  end

  // Held status, cleared when a new run starts
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      done <= 1'b0;
      program_error <= 1'b0;
      erase_error <= 1'b0;
    end else if (state_q == flash_seq_pkg::ST_IDLE && (start_program || start_erase)) begin
      done <= 1'b0;
      program_error <= 1'b0;
      erase_error <= 1'b0;
    end else if (state_q == flash_seq_pkg::ST_FINISH) begin
      done <= (result_q == flash_seq_pkg::RES_OK);
      program_error <= (result_q == flash_seq_pkg::RES_PROG_ERR);
      erase_error <= (result_q == flash_seq_pkg::RES_ERASE_ERR);
    end
  end

  // Programming supply request
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      program_supply_high_level <= 1'b0;
    end else if (state_q == flash_seq_pkg::ST_VPP_UP) begin
      program_supply_high_level <= 1'b1;
    end else if (state_q == flash_seq_pkg::ST_VPP_DN) begin
      program_supply_high_level <= 1'b0;
    end
  end

  // Sequencer
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q <= flash_seq_pkg::ST_IDLE;
      phase_q <= flash_seq_pkg::PH_PROG;
      result_q <= flash_seq_pkg::RES_OK;
      t_q <= 18'h00000;
      addr_q <= `FIRST_ADDR;
      end_q <= `FIRST_ADDR;
      data_q <= `CMD_READ;
      rd_q <= 8'h00;
      cnt_q <= 10'h000;
    end else begin
      if (!t_zero) begin
        t_q <= t_q - 18'h00001;
      end
      case (state_q)
        flash_seq_pkg::ST_IDLE: begin
          if (start_program) begin
            phase_q <= flash_seq_pkg::PH_PROG;
            addr_q <= prog_base;
            end_q <= prog_last;
            t_q <= 18'(`VPP_RAMP_CYC);
            state_q <= flash_seq_pkg::ST_VPP_UP;
          end else if (start_erase) begin
            phase_q <= flash_seq_pkg::PH_SCAN;
            addr_q <= `FIRST_ADDR;
            end_q <= `LAST_ADDR;
            t_q <= `RD_CYC;
            state_q <= flash_seq_pkg::ST_SCAN;
          end
        end
        flash_seq_pkg::ST_SCAN: begin
          if (t_zero) begin
            if (dq_sync_q != `ERASED_BYTE) begin
              phase_q <= flash_seq_pkg::PH_PRE;
              addr_q <= `FIRST_ADDR;
              t_q <= 18'(`VPP_RAMP_CYC);
              state_q <= flash_seq_pkg::ST_VPP_UP;
            end else if (addr_q == end_q) begin
              result_q <= flash_seq_pkg::RES_OK;
              state_q <= flash_seq_pkg::ST_FINISH;
            end else begin
              addr_q <= addr_q + 17'h00001;
              t_q <= `RD_CYC;
            end
          end
        end
        flash_seq_pkg::ST_VPP_UP: begin
          if (t_zero) begin
            state_q <= flash_seq_pkg::ST_FETCH;
          end
        end
        flash_seq_pkg::ST_FETCH: begin
          if (phase_q == flash_seq_pkg::PH_PRE || buf_valid) begin
            cnt_q <= 10'h000;
            data_q <= `CMD_PROG_SETUP;
            rd_q <= (phase_q == flash_seq_pkg::PH_PRE) ? `ZERO_BYTE : buf_data;
            t_q <= `WR_CYC;
            state_q <= flash_seq_pkg::ST_PSETUP;
          end
        end
        flash_seq_pkg::ST_PSETUP: begin
          if (t_zero) begin
            data_q <= rd_q;
            t_q <= `WR_CYC;
            state_q <= flash_seq_pkg::ST_PWRITE;
          end
        end
        flash_seq_pkg::ST_PWRITE: begin
          if (t_zero) begin
            t_q <= 18'(`PROG_PULSE_CYC);
            state_q <= flash_seq_pkg::ST_PPULSE;
          end
        end
        flash_seq_pkg::ST_PPULSE: begin
          if (t_zero) begin
            data_q <= `CMD_PROG_VERIFY;
            t_q <= `WR_CYC;
            state_q <= flash_seq_pkg::ST_PVERIFY;
          end
        end
        flash_seq_pkg::ST_PVERIFY: begin
          if (t_zero) begin
            data_q <= rd_q;
            t_q <= 18'(`SETTLE_CYC);
            state_q <= flash_seq_pkg::ST_PSETTLE;
          end
        end
        flash_seq_pkg::ST_PSETTLE: begin
          if (t_zero) begin
            t_q <= `RD_CYC;
            state_q <= flash_seq_pkg::ST_PREAD;
          end
        end
        flash_seq_pkg::ST_PREAD: begin
          if (t_zero) begin
            state_q <= flash_seq_pkg::ST_PCHECK;
          end
        end
        flash_seq_pkg::ST_PCHECK: begin
          if (dq_sync_q == data_q) begin
            if (addr_q != end_q) begin
              addr_q <= addr_q + 17'h00001;
              state_q <= flash_seq_pkg::ST_FETCH;
            end else if (phase_q == flash_seq_pkg::PH_PRE) begin
              phase_q <= flash_seq_pkg::PH_ERASE;
              addr_q <= `FIRST_ADDR;
              cnt_q <= 10'h000;
              data_q <= `CMD_ERASE;
              t_q <= `WR_CYC;
              state_q <= flash_seq_pkg::ST_ESETUP;
            end else begin
              result_q <= flash_seq_pkg::RES_OK;
              data_q <= `CMD_READ;
              t_q <= `WR_CYC;
              state_q <= flash_seq_pkg::ST_RDCMD;
            end
          end else if (cnt_q + 10'h001 == `PROG_MAX_PULSES) begin
            cnt_q <= cnt_q + 10'h001;
            result_q <= flash_seq_pkg::RES_PROG_ERR;
            data_q <= `CMD_READ;
            t_q <= `WR_CYC;
            state_q <= flash_seq_pkg::ST_RDCMD;
          end else begin
            cnt_q <= cnt_q + 10'h001;
            data_q <= `CMD_PROG_SETUP;
            rd_q <= data_q;
            t_q <= `WR_CYC;
            state_q <= flash_seq_pkg::ST_PSETUP;
          end
        end
        flash_seq_pkg::ST_ESETUP: begin
          if (t_zero) begin
            t_q <= `WR_CYC;
            state_q <= flash_seq_pkg::ST_EWRITE;
          end
        end
        flash_seq_pkg::ST_EWRITE: begin
          if (t_zero) begin
            t_q <= 18'(ERASE_PULSE_CYC);
            state_q <= flash_seq_pkg::ST_EPULSE;
          end
        end
        flash_seq_pkg::ST_EPULSE: begin
          if (t_zero) begin
            data_q <= `CMD_ERASE_VERIFY;
            t_q <= `WR_CYC;
            state_q <= flash_seq_pkg::ST_EVERIFY;
          end
        end
        flash_seq_pkg::ST_EVERIFY: begin
          if (t_zero) begin
            t_q <= 18'(`SETTLE_CYC);
            state_q <= flash_seq_pkg::ST_ESETTLE;
          end
        end
        flash_seq_pkg::ST_ESETTLE: begin
          if (t_zero) begin
            t_q <= `RD_CYC;
            state_q <= flash_seq_pkg::ST_EREAD;
          end
        end
        flash_seq_pkg::ST_EREAD: begin
          if (t_zero) begin
            state_q <= flash_seq_pkg::ST_ECHECK;
          end
        end
        flash_seq_pkg::ST_ECHECK: begin
          if (dq_sync_q == `ERASED_BYTE) begin
            if (addr_q == end_q) begin
              result_q <= flash_seq_pkg::RES_OK;
              data_q <= `CMD_READ;
              t_q <= `WR_CYC;
              state_q <= flash_seq_pkg::ST_RDCMD;
            end else begin
              addr_q <= addr_q + 17'h00001;
              data_q <= `CMD_ERASE_VERIFY;
              t_q <= `WR_CYC;
              state_q <= flash_seq_pkg::ST_EVERIFY;
            end
          end else if (cnt_q + 10'h001 == `ERASE_MAX_PULSES) begin
            cnt_q <= cnt_q + 10'h001;
            result_q <= flash_seq_pkg::RES_ERASE_ERR;
            data_q <= `CMD_READ;
            t_q <= `WR_CYC;
            state_q <= flash_seq_pkg::ST_RDCMD;
          end else begin
            cnt_q <= cnt_q + 10'h001;
            data_q <= `CMD_ERASE;
            t_q <= `WR_CYC;
            state_q <= flash_seq_pkg::ST_ESETUP;
          end
        end
        flash_seq_pkg::ST_RDCMD: begin
          if (t_zero) begin
            t_q <= 18'(`VPP_RAMP_CYC);
            state_q <= flash_seq_pkg::ST_VPP_DN;
          end
        end
        flash_seq_pkg::ST_VPP_DN: begin
          if (t_zero) begin
            state_q <= flash_seq_pkg::ST_FINISH;
          end
        end
        flash_seq_pkg::ST_FINISH: begin
          state_q <= flash_seq_pkg::ST_IDLE;
        end
        default: begin
          state_q <= flash_seq_pkg::ST_IDLE;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// ===== flash_seq_cfg.svh
// Constants for the flash program and erase sequencer
// Behaviour
// - Wait 10 us program pulse before verify
// - Verify-read the byte after every program pulse
// - At most 25 pulses per byte, else error
// - Programming supply high through pulses and verifies
// - Erase starts by reading; all FFH skips erase
// - Preprogram every byte to 00H before erasing
// - Erase set-up then erase write before verifying
// - Time erase pulse 10 ms before verify
// - Write A0H to start erase verify
// - Each erase verify write carries byte address
// - Wait 6 us after verify command before read
// - Verify from 0000H until end or mismatch
// - Mismatch bumps erase counter, pulses again
// - Erase counter reaching 1000 means erase error
// - Resume verification from last verified address
// - Compare program verify with intended byte
// - Program verify only right after program pulse
// - Write 00H when finished, then lower supply
// - Optional final read-compare pass, not done here
// - Program set-up 40H then address/data write
// - Program verify command C0H ends the pulse
// - Two 20H writes start an erase pulse
`ifndef FLASH_SEQ_CFG_SVH
`define FLASH_SEQ_CFG_SVH

`define CLK_MHZ 20
`define PROG_PULSE_US 10
`define ERASE_PULSE_MS 10
`define SETTLE_US 6
`define VPP_RAMP_US 1
`define PROG_PULSE_CYC ((`PROG_PULSE_US) * (`CLK_MHZ))
`define ERASE_PULSE_CYC ((`ERASE_PULSE_MS) * 1000 * (`CLK_MHZ))
`define SETTLE_CYC ((`SETTLE_US) * (`CLK_MHZ))
`define VPP_RAMP_CYC ((`VPP_RAMP_US) * (`CLK_MHZ))
`define WR_CYC 18'h00003
`define RD_CYC 18'h00006

`define CMD_READ 8'h00
`define CMD_PROG_SETUP 8'h40
`define CMD_PROG_VERIFY 8'hC0
`define CMD_ERASE 8'h20
`define CMD_ERASE_VERIFY 8'hA0
`define ERASED_BYTE 8'hFF
`define ZERO_BYTE 8'h00

`define PROG_MAX_PULSES 10'h019
`define ERASE_MAX_PULSES 10'h3E8
`define FIRST_ADDR 17'h00000
`define LAST_ADDR 17'h1FFFF

`endif

// ===== flash_seq_pkg.sv
// Types shared by the flash sequencer
`default_nettype none
package flash_seq_pkg;
  typedef enum logic [4:0] {
    ST_IDLE = 5'h00,
    ST_SCAN = 5'h01,
    ST_VPP_UP = 5'h03,
    ST_FETCH = 5'h02,
    ST_PSETUP = 5'h06,
    ST_PWRITE = 5'h07,
    ST_PPULSE = 5'h05,
    ST_PVERIFY = 5'h04,
    ST_PSETTLE = 5'h0C,
    ST_PREAD = 5'h0D,
    ST_PCHECK = 5'h0F,
    ST_ESETUP = 5'h0E,
    ST_EWRITE = 5'h0A,
    ST_EPULSE = 5'h0B,
    ST_EVERIFY = 5'h09,
    ST_ESETTLE = 5'h08,
    ST_EREAD = 5'h18,
    ST_ECHECK = 5'h19,
    ST_RDCMD = 5'h1B,
    ST_VPP_DN = 5'h1A,
    ST_FINISH = 5'h1E
  } state_e;

  typedef enum logic [1:0] {
    PH_PROG = 2'h0,
    PH_SCAN = 2'h1,
    PH_PRE = 2'h2,
    PH_ERASE = 2'h3
  } phase_e;

  typedef enum logic [1:0] {
    RES_OK = 2'h0,
    RES_PROG_ERR = 2'h1,
    RES_ERASE_ERR = 2'h2
  } result_e;
endpackage
`default_nettype wire

// ===== flash_seq_props.sv
// Port checker for the flash program and erase sequencer
`default_nettype none
module flash_seq_props #(
  parameter int ERASE_PULSE_CYC = 50
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic start_program,
  input wire logic start_erase,
  input wire logic busy,
  input wire logic done,
  input wire logic program_error,
  input wire logic erase_error,
  input wire logic [9:0] pulse_counter,
  input wire logic program_supply_high_level,
  input wire logic [7:0] mem_dq_o,
  input wire logic mem_dq_oe,
  input wire logic mem_we_n,
  input wire logic mem_oe_n
);
  logic we_n_q;
  logic [15:0] since_q;
  logic [7:0] last_wr_q;
  always_ff @(posedge clk) begin
    if (!rst_n) we_n_q <= 1'b1;
    else we_n_q <= mem_we_n;
  end
  // Cycles since the last write strobe ended, and the byte that write carried
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      since_q <= 16'h0000;
      last_wr_q <= 8'h00;
    end else if (mem_we_n && !we_n_q) begin
      since_q <= 16'h0000;
      last_wr_q <= mem_dq_o;
    end else if (since_q != 16'hFFFF) begin
      since_q <= since_q + 16'h0001;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence wr_end_s(logic [7:0] code);
    $rose(mem_we_n) && mem_dq_o == code;
  endsequence
  sequence verify_read_s;
    ##[1:140] $fell(mem_oe_n);
  endsequence
  we_strobe_a: assert property ($fell(mem_we_n) |-> ##1 !mem_we_n ##1 mem_we_n)
    else $error("write strobe width wrong");
  dq_driven_a: assert property (!mem_we_n |-> mem_dq_oe)
    else $error("data not driven during write strobe");
  write_supply_a: assert property ($fell(mem_we_n) |-> program_supply_high_level)
    else $error("command write with supply low");
  pulse_time_a: assert property (wr_end_s(8'hC0) |-> since_q >= 16'h00C8)
    else $error("program pulse too short");
  verify_read_a: assert property (wr_end_s(8'hC0) |-> verify_read_s)
    else $error("no verify read after program pulse");
  settle_time_a: assert property ($fell(mem_oe_n) && program_supply_high_level |-> since_q >= 16'h0078)
    else $error("verify read too soon");
  supply_off_a: assert property ($fell(program_supply_high_level) |-> last_wr_q == 8'h00)
    else $error("supply lowered without read command");
  idle_quiet_a: assert property (!busy |-> !program_supply_high_level && mem_we_n)
    else $error("idle with supply high or write active");
  status_hold_a: assert property (done && !busy && !start_program && !start_erase |=> done)
    else $error("done not held");
  start_clear_a: assert property (!busy && (start_program || start_erase) |=>
    busy ##1 (!done && !program_error && !erase_error))
    else $error("start not taken or status not cleared");
  error_count_a: assert property ($rose(program_error) |-> pulse_counter == 10'h019 && !done)
    else $error("program error at wrong pulse count");
endmodule
bind flash_program_erase_algorithm flash_seq_props #(.ERASE_PULSE_CYC(ERASE_PULSE_CYC)) i_props (
  .clk(clk), .rst_n(rst_n), .start_program(start_program), .start_erase(start_erase), .busy(busy),
  .done(done), .program_error(program_error), .erase_error(erase_error), .pulse_counter(pulse_counter),
  .program_supply_high_level(program_supply_high_level), .mem_dq_o(mem_dq_o), .mem_dq_oe(mem_dq_oe),
  .mem_we_n(mem_we_n), .mem_oe_n(mem_oe_n));
`default_nettype wire

// ===== testbench.sv
// Self-checking testbench for the flash program and erase sequencer
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic start_program = 1'b0;
  logic start_erase = 1'b0;
  logic [16:0] prog_base = 17'h00000;
  logic [16:0] prog_last = 17'h00000;
  logic wr_valid = 1'b0;
  logic [7:0] wr_data = 8'h00;
  logic wr_ready, busy, done, program_error, erase_error, supply, dq_oe, we_n, oe_n, ce_n;
  logic [9:0] pulse_counter;
  logic [16:0] mem_addr;
  logic [7:0] dq_i, dq_o;
  int miscompares = 0;
  int n_checks = 0;
  int cycles = 0;
  flash_program_erase_algorithm #(.ERASE_PULSE_CYC(50)) i_dut (
    .clk(clk), .rst_n(rst_n), .start_program(start_program), .start_erase(start_erase),
    .prog_base(prog_base), .prog_last(prog_last), .wr_valid(wr_valid), .wr_data(wr_data),
    .wr_ready(wr_ready), .busy(busy), .done(done), .program_error(program_error), .erase_error(erase_error),
    .pulse_counter(pulse_counter), .program_supply_high_level(supply), .mem_addr(mem_addr),
    .mem_dq_i(dq_i), .mem_dq_o(dq_o), .mem_dq_oe(dq_oe), .mem_we_n(we_n), .mem_oe_n(oe_n), .mem_ce_n(ce_n));
  flash_array_model i_mem (.mem_addr(mem_addr), .mem_dq_o(dq_o), .mem_we_n(we_n), .mem_oe_n(oe_n),
    .mem_ce_n(ce_n), .vpp_high(supply), .mem_dq_i(dq_i));
  initial forever #25 clk = ~clk;
  task automatic give_verdict();
    if (miscompares == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      miscompares++;
      give_verdict();
    end
  end
  task automatic check(string what, logic [31:0] exp, logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  function automatic int count(logic [7:0] code);
    int c = 0;
    foreach (i_mem.log_q[k]) if (i_mem.log_q[k] === code) c++;
    return c;
  endfunction
  task automatic push(logic [7:0] b);
    @(negedge clk);
    wr_valid = 1'b1;
    wr_data = b;
    // Ready is settled at the falling edge and holds to the rising edge that takes the byte
    while (wr_ready !== 1'b1) @(negedge clk);
    @(negedge clk);
    wr_valid = 1'b0;
  endtask
  task automatic run(logic [16:0] base, logic [16:0] last);
    @(negedge clk);
    start_program = 1'b1;
    prog_base = base;
    prog_last = last;
    @(negedge clk);
    start_program = 1'b0;
    while (busy !== 1'b0) @(negedge clk);
  endtask
  task automatic t_stream();
    logic [7:0] exp_q[$] = '{8'h40, 8'hA5, 8'hC0, 8'h40, 8'h3C, 8'hC0, 8'h40, 8'h96, 8'hC0, 8'h00};
    push(8'hA5);
    push(8'h3C);
    @(negedge clk);
    check("ready with buffer full", 0, wr_ready);
    i_mem.log_q.delete();
    fork
      run(17'h00010, 17'h00012);
      push(8'h96);
    join
    check("done", 1, done);
    check("byte at 10h", 8'hA5, i_mem.rd(16));
    check("byte at 12h", 8'h96, i_mem.rd(18));
    check("command count", 10, i_mem.log_q.size());
    foreach (exp_q[k]) check("command byte", exp_q[k], i_mem.log_q[k]);
    check("supply after run", 0, supply);
  endtask
  task automatic t_retry();
    push(8'h5A);
    i_mem.fails = 2;
    i_mem.log_q.delete();
    fork
      run(17'h00020, 17'h00020);
      begin
        repeat (10) @(negedge clk);
        start_erase = 1'b1;
        @(negedge clk);
        start_erase = 1'b0;
      end
    join
    check("done after retries", 1, done);
    check("failed verifies counted", 10'h002, pulse_counter);
    check("verify commands", 3, count(8'hC0));
    check("erase writes while busy", 0, count(8'h20));
    check("byte at 20h", 8'h5A, i_mem.rd(32));
  endtask
  task automatic t_limit();
    push(8'h77);
    i_mem.fails = 100;
    i_mem.log_q.delete();
    run(17'h00030, 17'h00030);
    i_mem.fails = 0;
    check("program error", 1, program_error);
    check("done on error", 0, done);
    check("no erase error", 0, erase_error);
    check("pulse count at error", 10'h019, pulse_counter);
    check("pulses applied", 25, count(8'hC0));
    check("supply after error", 0, supply);
  endtask
  task automatic t_erase_reset();
    int n = 0;
    i_mem.log_q.delete();
    @(negedge clk);
    start_erase = 1'b1;
    @(negedge clk);
    start_erase = 1'b0;
    while (oe_n !== 1'b0 && n < 100) begin
      n++;
      @(negedge clk);
    end
    check("first scan address", 17'h00000, mem_addr);
    repeat (60) @(negedge clk);
    check("scan supply", 0, supply);
    check("scan writes", 0, i_mem.log_q.size());
    // Byte 10h holds data, so the scan turns into a preprogram pass from address zero
    repeat (150) @(negedge clk);
    check("preprogram supply", 1, supply);
    check("preprogram setup", 8'h40, i_mem.log_q[0]);
    check("preprogram data", 8'h00, i_mem.log_q[1]);
    check("preprogram address", 17'h00000, mem_addr);
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    check("busy in reset", 0, busy);
    check("write strobe in reset", 1, we_n);
    check("supply in reset", 0, supply);
    rst_n = 1'b1;
    push(8'hE1);
    run(17'h00040, 17'h00040);
    check("done after reset", 1, done);
    check("byte at 40h", 8'hE1, i_mem.rd(64));
  endtask
  initial begin
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    t_stream();
    t_retry();
    t_limit();
    t_erase_reset();
    check("device protocol faults", 0, i_mem.viol);
    give_verdict();
  end
endmodule
`default_nettype wire

// ===== word_buffer2.sv
// Two-entry byte buffer with valid/ready on both sides
`default_nettype none
module word_buffer2 (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  input wire logic [7:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [7:0] out_data,
  input wire logic out_ready
);
  logic [7:0] mem_q [2];
  logic wr_ptr_q;
  logic rd_ptr_q;
  logic [1:0] count_q;
  logic push;
  logic pop;

  assign in_ready = (count_q != 2'h2);
  assign out_valid = (count_q != 2'h0);
  assign out_data = mem_q[rd_ptr_q];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_ptr_q] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wr_ptr_q <= 1'b0;
      rd_ptr_q <= 1'b0;
      count_q <= 2'h0;
    end else begin
      if (push) begin
        wr_ptr_q <= ~wr_ptr_q;
      end
      if (pop) begin
        rd_ptr_q <= ~rd_ptr_q;
      end
      if (push && !pop) begin
        count_q <= count_q + 2'h1;
      end else if (pop && !push) begin
        count_q <= count_q - 2'h1;
      end
    end
  end
endmodule
`default_nettype wire
